// ===== dts_params.svh
// Register field positions and constants for the die temperature sensor block
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
`define DTS_ST_HOT 0
`define DTS_ST_HOT_LOG 1
`define DTS_ST_HOTF 2
`define DTS_ST_HOTF_LOG 3
`define DTS_ST_OVH 4
`define DTS_ST_OVH_LOG 5
`define DTS_ST_TH1 6
`define DTS_ST_TH1_LOG 7
`define DTS_ST_TH2 8
`define DTS_ST_TH2_LOG 9
`define DTS_ST_RD_LO 16
`define DTS_ST_RD_HI 22
`define DTS_ST_RES_LO 27
`define DTS_ST_RES_HI 30
`define DTS_ST_VALID 31
`define DTS_CT_HI_EN 0
`define DTS_CT_LO_EN 1
`define DTS_CT_TRIP_EN 2
`define DTS_CT_FORCE_EN 3
`define DTS_CT_OVH_EN 4
`define DTS_CT_TH1_LO 8
`define DTS_CT_TH1_HI 14
`define DTS_CT_TH1_EN 15
`define DTS_CT_TH2_LO 16
`define DTS_CT_TH2_HI 22
`define DTS_CT_TH2_EN 23
`define DTS_CT_WMASK 32'h00FF_FF1F
`define DTS_CTRL_RESET 32'h0000_0000
`define DTS_NUM_THRESH 4'h2
`define DTS_SENSOR_PRESENT 1'h1
`endif

// ===== dts_pkg.sv
// Types for the die temperature sensor block
package dts_pkg;
    typedef logic [31:0] dts_word_t;
    typedef logic [6:0] dts_temp_t;
    typedef logic [3:0] dts_res_t;
endpackage

// ===== dts_status_irq.sv
// Die temperature sensor status, threshold and interrupt request logic
`timescale 1ns/10ps
`include "dts_params.svh"
// Behaviour
// - Status bit 0 mirrors the hot/throttle signal live; writes ignored.
// - Status bit 1 latches hot/throttle assertion; software clears by writing zero.
// - Status bit 2 high while hot/throttle or external force-throttle active.
// - Status bit 3 latches hot or force assertion; write zero clears.
// - Status bit 4 high while overheat detector active.
// - Status bit 5 latches overheat assertion; write zero clears.
// - Status bit 6 high while temperature at or above first threshold.
// - Status bit 7 latches first threshold reached; write zero clears.
// - Status bit 8 high while temperature at or above second threshold.
// - Status bit 9 latches second threshold reached; write zero clears.
// - Status bits 22:16 give degrees below maximum junction temperature.
// - Reading never shows hotter than maximum; overheat flag covers that.
// - Status bits 30:27 give resolution; software keeps thresholds apart.
// - Status bit 31 set only while reading is valid.
// - Control bit 0 enables interrupt on low-to-high temperature transition.
// - Control bit 1 enables interrupt on high-to-low temperature transition.
// - Control bit 2 enables catastrophic-trip interrupt; trip shuts down.
// - Control bit 3 enables force-throttle interrupt when external hot asserts.
// - Control bit 4 enables overheat interrupt.
// - Control bits 14:8 first threshold, bit 15 its interrupt enable.
// - Control bits 22:16 second threshold, bit 23 its interrupt enable.
// - Identification reports sensor present and number of thresholds.
module dts_status_irq (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hot_throttle_signal,
    input wire logic external_force_throttle,
    input wire logic overheat_detect,
    input wire logic catastrophic_trip_signal,
    input wire dts_pkg::dts_temp_t sensor_reading,
    input wire logic sensor_reading_valid,
    input wire dts_pkg::dts_res_t sensor_resolution,
    input wire logic status_wr,
    input wire dts_pkg::dts_word_t status_wdata,
    input wire logic ctrl_wr,
    input wire dts_pkg::dts_word_t ctrl_wdata,
    output dts_pkg::dts_word_t status_rdata,
    output dts_pkg::dts_word_t ctrl_rdata,
    output logic thermal_irq,
    output logic shutdown_req,
    output logic id_sensor_present,
    output logic [3:0] id_num_thresholds
);
    import dts_pkg::*;

    // Control register
    dts_word_t ctrl_q;

    // Live flags
    logic hot_q;
    logic hotf_q;
    logic ovh_q;
    logic th1_q;
    logic th2_q;
    logic trip_q;
    logic frc_q;

    // Sticky logs and edge history
    logic hot_log_q;
    logic hotf_log_q;
    logic ovh_log_q;
    logic th1_log_q;
    logic th2_log_q;
    logic hot_prev_q;
    logic ovh_prev_q;
    logic th1_prev_q;
    logic th2_prev_q;
    logic trip_prev_q;
    logic frc_prev_q;

    // Readout fields
    logic valid_q;
    dts_temp_t reading_q;
    dts_res_t res_q;

    // Outputs before their image flops
    logic irq_q;
    logic shut_q;

    // Threshold and force compare
    logic th1_d;
    logic th2_d;
    logic hotf_d;
    logic [6:0] th1_val;
    logic [6:0] th2_val;

    assign th1_val = ctrl_q[`DTS_CT_TH1_HI:`DTS_CT_TH1_LO];
    assign th2_val = ctrl_q[`DTS_CT_TH2_HI:`DTS_CT_TH2_LO];
    // threshold compare
    // Relative readout: smaller value means hotter, so at-or-above is less-or-equal
    assign th1_d = sensor_reading_valid && (sensor_reading <= th1_val);
    assign th2_d = sensor_reading_valid && (sensor_reading <= th2_val);
    assign hotf_d = hot_throttle_signal | external_force_throttle;

    // control register
    // Reserved bits masked so they always read back as zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `DTS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata & `DTS_CT_WMASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hot_q <= 1'b0;
            hotf_q <= 1'b0;
            ovh_q <= 1'b0;
            th1_q <= 1'b0;
            th2_q <= 1'b0;
            trip_q <= 1'b0;
            frc_q <= 1'b0;
        end else begin
            hot_q <= hot_throttle_signal;
            hotf_q <= hotf_d;
            ovh_q <= overheat_detect;
            th1_q <= th1_d;
            th2_q <= th2_d;
            trip_q <= catastrophic_trip_signal;
            frc_q <= external_force_throttle;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= 1'b0;
            reading_q <= 7'h00;
            res_q <= 4'h0;
        end else begin
            valid_q <= sensor_reading_valid;
            reading_q <= sensor_reading_valid ? sensor_reading : 7'h00;
            res_q <= sensor_resolution;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trip_prev_q <= 1'b0;
            frc_prev_q <= 1'b0;
        end else begin
            trip_prev_q <= trip_q;
            frc_prev_q <= frc_q;
        end
    end

    // sticky logs
    // Edge history sits beside each log so the log and the request see one edge
    dts_sticky_log #(
        .CLR_BIT(`DTS_ST_HOT_LOG)
    ) u_hot_log (
        .clk(clk),
        .arst_n(arst_n),
        .live(hot_q),
        .wr(status_wr),
        .wdata(status_wdata),
        .prev_q(hot_prev_q),
        .sticky_q(hot_log_q)
    );

    dts_sticky_log #(
        .CLR_BIT(`DTS_ST_HOTF_LOG)
    ) u_hotf_log (
        .clk(clk),
        .arst_n(arst_n),
        .live(hotf_q),
        .wr(status_wr),
        .wdata(status_wdata),
        .prev_q(),
        .sticky_q(hotf_log_q)
    );

    dts_sticky_log #(
        .CLR_BIT(`DTS_ST_OVH_LOG)
    ) u_ovh_log (
        .clk(clk),
        .arst_n(arst_n),
        .live(ovh_q),
        .wr(status_wr),
        .wdata(status_wdata),
        .prev_q(ovh_prev_q),
        .sticky_q(ovh_log_q)
    );

    dts_sticky_log #(
        .CLR_BIT(`DTS_ST_TH1_LOG)
    ) u_th1_log (
        .clk(clk),
        .arst_n(arst_n),
        .live(th1_q),
        .wr(status_wr),
        .wdata(status_wdata),
        .prev_q(th1_prev_q),
        .sticky_q(th1_log_q)
    );

    dts_sticky_log #(
        .CLR_BIT(`DTS_ST_TH2_LOG)
    ) u_th2_log (
        .clk(clk),
        .arst_n(arst_n),
        .live(th2_q),
        .wr(status_wr),
        .wdata(status_wdata),
        .prev_q(th2_prev_q),
        .sticky_q(th2_log_q)
    );

    // one-cycle request per enabled edge
    // Events in one cycle merge into a single pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <=
                (ctrl_q[`DTS_CT_HI_EN] & hot_q & ~hot_prev_q)
                | (ctrl_q[`DTS_CT_LO_EN] & ~hot_q & hot_prev_q)
                | (ctrl_q[`DTS_CT_TRIP_EN] & trip_q & ~trip_prev_q)
                | (ctrl_q[`DTS_CT_FORCE_EN] & frc_q & ~frc_prev_q)
                | (ctrl_q[`DTS_CT_OVH_EN] & ovh_q & ~ovh_prev_q)
                | (ctrl_q[`DTS_CT_TH1_EN] & (th1_q ^ th1_prev_q))
                | (ctrl_q[`DTS_CT_TH2_EN] & (th2_q ^ th2_prev_q));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_q <= 1'b0;
        end else if (trip_q) begin
            shut_q <= 1'b1;
        end
    end

    // Status image registered so reads come straight from flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_rdata <= 32'h0000_0000;
        end else begin
            status_rdata <= 32'h0000_0000;
            status_rdata[`DTS_ST_HOT] <= hot_q;
            status_rdata[`DTS_ST_HOT_LOG] <= hot_log_q;
            status_rdata[`DTS_ST_HOTF] <= hotf_q;
            status_rdata[`DTS_ST_HOTF_LOG] <= hotf_log_q;
            status_rdata[`DTS_ST_OVH] <= ovh_q;
            status_rdata[`DTS_ST_OVH_LOG] <= ovh_log_q;
            status_rdata[`DTS_ST_TH1] <= th1_q;
            status_rdata[`DTS_ST_TH1_LOG] <= th1_log_q;
            status_rdata[`DTS_ST_TH2] <= th2_q;
            status_rdata[`DTS_ST_TH2_LOG] <= th2_log_q;
            status_rdata[`DTS_ST_RD_HI:`DTS_ST_RD_LO] <= reading_q;
            status_rdata[`DTS_ST_RES_HI:`DTS_ST_RES_LO] <= res_q;
            status_rdata[`DTS_ST_VALID] <= valid_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_rdata <= 32'h0000_0000;
        end else begin
            ctrl_rdata <= ctrl_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            thermal_irq <= 1'b0;
        end else begin
            thermal_irq <= irq_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_req <= 1'b0;
        end else begin
            shutdown_req <= shut_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            id_sensor_present <= 1'b0;
            id_num_thresholds <= 4'h0;
        end else begin
            id_sensor_present <= `DTS_SENSOR_PRESENT;
            id_num_thresholds <= `DTS_NUM_THRESH;
        end
    end
endmodule // dts_status_irq

// Sticky log flag with its own edge history
module dts_sticky_log #(
    parameter int CLR_BIT = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic live,
    input wire logic wr,
    input wire dts_pkg::dts_word_t wdata,
    output logic prev_q,
    output logic sticky_q
);
    import dts_pkg::*;

    logic clr;
    logic rise;

    // Writing zero clears; writing one leaves the flag alone
    assign clr = wr & ~wdata[CLR_BIT];
    assign rise = live & ~prev_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= live;
        end
    end

    // Set beats clear so an event landing on a clear write is kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sticky_q <= 1'b0;
        end else begin
            sticky_q <= rise | (sticky_q & ~clr);
        end
    end
endmodule // dts_sticky_log

// ===== dts_irq_sink.sv
// Local interrupt controller model counting thermal requests
`timescale 1ns/10ps
module dts_irq_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic thermal_irq,
    output int irq_count
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_count <= 0;
        end else if (thermal_irq) begin
            irq_count <= irq_count + 1;
        end
    end
endmodule // dts_irq_sink

// ===== dts_status_irq_monitor.sv
// Port checker for the die temperature status and interrupt block
`timescale 1ns/10ps
`include "dts_params.svh"
module dts_status_irq_mon (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hot_throttle_signal,
    input wire logic external_force_throttle,
    input wire logic overheat_detect,
    input wire logic sensor_reading_valid,
    input wire logic status_wr,
    input wire dts_pkg::dts_word_t status_wdata,
    input wire logic ctrl_wr,
    input wire dts_pkg::dts_word_t ctrl_wdata,
    input wire dts_pkg::dts_word_t status_rdata,
    input wire dts_pkg::dts_word_t ctrl_rdata,
    input wire logic thermal_irq,
    input wire logic shutdown_req,
    input wire logic id_sensor_present,
    input wire logic [3:0] id_num_thresholds
);
    import dts_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Two edges: input flop, then image flop
    chk_hot_live: assert property (status_rdata[0] == $past(hot_throttle_signal, 2)) else $error("hot live");
    chk_hot_log: assert property ($rose(status_rdata[0]) |=> status_rdata[1]) else $error("hot log set");
    chk_log_clear: assert property ($fell(status_rdata[1]) |-> $past(status_wr, 2) && !$past(status_wdata[1], 2))
        else $error("hot log cleared alone");
    chk_force_live: assert property (status_rdata[2] == $past(hot_throttle_signal | external_force_throttle, 2))
        else $error("force live");
    chk_ovh_live: assert property (status_rdata[4] == $past(overheat_detect, 2)) else $error("overheat live");
    chk_valid_bit: assert property (status_rdata[31] == $past(sensor_reading_valid, 2))
        else $error("valid bit");
    chk_ctrl_write: assert property ($past(ctrl_wr, 2) |-> ctrl_rdata == ($past(ctrl_wdata, 2) & `DTS_CT_WMASK))
        else $error("control write");
    chk_irq_off: assert property ($past(ctrl_rdata) == 32'h0000_0000 |-> !thermal_irq)
        else $error("irq disabled");
    chk_irq_hot: assert property ($past(ctrl_rdata[0]) && $past(hot_throttle_signal, 3)
        && !$past(hot_throttle_signal, 4) |-> thermal_irq) else $error("hot irq missing");
    chk_trip_hold: assert property (shutdown_req |=> shutdown_req) else $error("shutdown dropped");
    chk_id_fixed: assert property ($past(arst_n) |-> id_sensor_present && id_num_thresholds == 4'h2)
        else $error("id fields");
endmodule // dts_status_irq_mon
bind dts_status_irq dts_status_irq_mon u_mon (.clk, .arst_n, .hot_throttle_signal, .external_force_throttle,
    .overheat_detect, .sensor_reading_valid, .status_wr, .status_wdata, .ctrl_wr, .ctrl_wdata, .status_rdata,
    .ctrl_rdata, .thermal_irq, .shutdown_req, .id_sensor_present, .id_num_thresholds);

// ===== tb_dts_status_irq.sv
// Self-checking bench for the die temperature status and interrupt block
`timescale 1ns/10ps
`include "dts_params.svh"
module tb_dts_status_irq;
    import dts_pkg::*;
    logic clk, arst_n, hot, frc, ovh, trip, valid, status_wr, ctrl_wr, irq, sd, idp;
    logic [3:0] idn;
    dts_temp_t rd;
    dts_res_t res;
    dts_word_t status_wdata, ctrl_wdata, st, ct;
    int irqs, fail_count = 0, comparisons = 0, cycles = 0;
    dts_status_irq dut (.clk, .arst_n, .hot_throttle_signal(hot), .external_force_throttle(frc),
        .overheat_detect(ovh), .catastrophic_trip_signal(trip), .sensor_reading(rd), .sensor_reading_valid(valid),
        .sensor_resolution(res), .status_wr, .status_wdata, .ctrl_wr, .ctrl_wdata, .status_rdata(st),
        .ctrl_rdata(ct), .thermal_irq(irq), .shutdown_req(sd), .id_sensor_present(idp), .id_num_thresholds(idn));
    dts_irq_sink u_sink (.clk, .arst_n, .thermal_irq(irq), .irq_count(irqs));
    task automatic cmp_word(dts_word_t got, dts_word_t exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmp_int(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %0d requests, wanted %0d", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Strobe for one edge, so each write is taken once
    task automatic wr(bit to_status, dts_word_t v);
        @(posedge clk);
        status_wr <= to_status;
        ctrl_wr <= !to_status;
        status_wdata <= v;
        ctrl_wdata <= v;
        @(posedge clk);
        status_wr <= 1'b0;
        ctrl_wr <= 1'b0;
        settle();
    endtask
    task automatic t_regs();
        cmp_word(ct, `DTS_CTRL_RESET);
        cmp_word({27'h0, idp, idn}, {27'h0, `DTS_SENSOR_PRESENT, `DTS_NUM_THRESH});
        wr(1'b0, 32'hFFFF_FFFF);
        cmp_word(ct, `DTS_CT_WMASK);
        $display("test regs done");
    endtask
    task automatic t_hot();
        wr(1'b0, 32'h0000_0003);
        @(posedge clk);
        hot <= 1'b1;
        settle();
        cmp_word(st, 32'h0000_000F);
        cmp_int(irqs, 1);
        wr(1'b1, 32'hFFFF_FFFF);
        cmp_word(st, 32'h0000_000F);
        @(posedge clk);
        hot <= 1'b0;
        settle();
        cmp_word(st, 32'h0000_000A);
        cmp_int(irqs, 2);
        wr(1'b1, 32'h0000_0000);
        cmp_word(st, 32'h0000_0000);
        $display("test hot done");
    endtask
    task automatic t_force();
        wr(1'b0, 32'h0000_0008);
        @(posedge clk);
        frc <= 1'b1;
        settle();
        cmp_word(st, 32'h0000_000C);
        cmp_int(irqs, 3);
        @(posedge clk);
        frc <= 1'b0;
        $display("test force done");
    endtask
    task automatic t_ovh();
        wr(1'b0, 32'h0000_0014);
        wr(1'b1, 32'h0000_0000);
        @(posedge clk);
        ovh <= 1'b1;
        settle();
        cmp_word(st, 32'h0000_0030);
        cmp_int(irqs, 4);
        @(posedge clk);
        trip <= 1'b1;
        ovh <= 1'b0;
        settle();
        cmp_word({31'h0, sd}, 32'h0000_0001);
        cmp_int(irqs, 5);
        cmp_word(st, 32'h0000_0020);
        $display("test overheat done");
    endtask
    task automatic t_thresh();
        wr(1'b1, 32'h0000_0000);
        wr(1'b0, 32'h001E_0A00);
        @(posedge clk);
        valid <= 1'b1;
        rd <= 7'h14;
        res <= 4'h3;
        settle();
        cmp_word(st, 32'h9814_0300);
        @(posedge clk);
        rd <= 7'h0A;
        settle();
        cmp_word(st, 32'h980A_03C0);
        @(posedge clk);
        valid <= 1'b0;
        settle();
        cmp_word(st, 32'h1800_0280);
        cmp_int(irqs, 5);
        wr(1'b0, 32'h0000_8A00);
        @(posedge clk);
        valid <= 1'b1;
        rd <= 7'h05;
        settle();
        cmp_int(irqs, 6);
        wr(1'b0, 32'h0086_0000);
        cmp_int(irqs, 7);
        cmp_word(st, 32'h9805_0380);
        $display("test threshold done");
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run needs some 140 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        {arst_n, hot, frc, ovh, trip, valid, status_wr, ctrl_wr} = 8'h00;
        {rd, res, status_wdata, ctrl_wdata} = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        settle();
        t_regs();
        t_hot();
        t_force();
        t_ovh();
        t_thresh();
        close_out();
    end
endmodule // tb_dts_status_irq
